//--- hdl/brc_pkg.sv
// Shared constants for the bidirectional reset control block
package brc_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_SYS_CONFIG   = 8'h00;
  localparam logic [7:0] OFS_RESET_STATUS = 8'h04;
  localparam logic [7:0] OFS_CONFIG_LATCH = 8'h08;

  // System configuration field positions
  localparam int unsigned BIT_EXP_EN   = 2;
  localparam int unsigned BIT_BIDIR    = 3;
  localparam int unsigned BIT_INITDONE = 8;

  // Reset status field positions
  localparam int unsigned BIT_HW_LONG  = 0;
  localparam int unsigned BIT_HW_SHORT = 1;
  localparam int unsigned BIT_SW       = 2;
  localparam int unsigned BIT_WDT      = 3;

  // Boot select sits on bit 4 of the configuration port
  localparam int unsigned BIT_BOOT_SEL = 4;

  // Values after power-on reset
  localparam logic [15:0] RST_SYS_CONFIG   = 16'h0000;
  localparam logic [15:0] RST_RESET_STATUS = 16'h0000;
  localparam logic [15:0] RST_CONFIG_LATCH = 16'h0000;

  // Timing: clock period and spike filter, in ns
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SPIKE_NS      = 10;
  // Least time rounds up to whole cycles
  localparam int unsigned SPIKE_CYC     = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SEQ_CYC       = 1024;

  // Cause of the reset under way
  typedef enum logic [1:0] {
    BRC_CAUSE_HW,
    BRC_CAUSE_SW,
    BRC_CAUSE_WDT
  } brc_cause_t;

endpackage

//--- hdl/brc_seq_if.sv
// Handshake between reset controller and sequence timer
`timescale 1ns/1ns
`default_nettype none
interface brc_seq_if;
  logic start;
  logic done;
  modport ctrl  (output start, input done);
  modport timer (input start, output done);
endinterface
`default_nettype wire

//--- hdl/brc_seq_timer.sv
// Internal reset sequence timer
`timescale 1ns/1ns
`default_nettype none
module brc_seq_timer
  import brc_pkg::*;
#(
  parameter int unsigned CYCLES = SEQ_CYC
) (
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  sys_rst,
  // Handshake to controller
  brc_seq_if.timer   seq
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count;
  logic          running;

  // Counts down from start; done pulses when the sequence expires
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count   <= '0;
      running <= 1'b0;
      seq.done <= 1'b0;
    end else if (seq.start) begin
      count    <= CW'(CYCLES - 1);
      running  <= 1'b1;
      seq.done <= 1'b0;
    end else if (running && count == '0) begin
      running  <= 1'b0;
      seq.done <= 1'b1;
    end else begin
      if (running) begin
        count <= count - 1'b1;
      end
      seq.done <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- hdl/brc_reset_ctrl.sv
// Reset controller with bidirectional reset pin and expansion enables
`timescale 1ns/1ns
`default_nettype none

module brc_reset_ctrl
  import brc_pkg::*;
#(
  parameter int unsigned SEQ_CYCLES = SEQ_CYC
) (
  // Clock and power-on reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // External reset pin, open drain
  input  wire logic              external_reset_line_in,
  output logic                   external_reset_line_out,
  output logic                   external_reset_line_oe,
  // Strap and configuration pins
  input  wire logic              external_access_pin,
  input  wire logic [15:0]       config_port,
  // Core side events
  input  wire logic              osc_running,
  input  wire logic              sw_reset_req,
  input  wire logic              wdt_reset_req,
  input  wire logic              end_of_init_instruction,
  // Reset and configuration outputs
  output logic                   core_reset,
  output logic      [15:0]       config_latched,
  output logic                   bootstrap_start,
  // Expansion bus resource enables
  output logic                   ext_ram_enable,
  output logic                   bus_ctrl_enable,
  output logic                   serial_enable
);

  typedef enum logic [2:0] {
    BRC_IDLE,
    BRC_SEQ,
    BRC_WAIT_HIGH,
    BRC_END
  } brc_state_t;

  brc_seq_if seq ();

  brc_seq_timer #(
    .CYCLES (SEQ_CYCLES)
  ) u_timer (
    .clock   (clock),
    .sys_rst (sys_rst),
    .seq     (seq.timer)
  );

  // Pin synchronisers; first stages feed only the second stages
  logic        line_meta;
  logic        line_sync;
  logic        acc_meta;
  logic        acc_sync;
  logic [15:0] cfg_meta;
  logic [15:0] cfg_sync;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      line_meta <= 1'b1;
      line_sync <= 1'b1;
      acc_meta  <= 1'b1;
      acc_sync  <= 1'b1;
      cfg_meta  <= 16'h0000;
      cfg_sync  <= 16'h0000;
    end else begin
      line_meta <= external_reset_line_in;
      line_sync <= line_meta;
      acc_meta  <= external_access_pin;
      acc_sync  <= acc_meta;
      cfg_meta  <= config_port;
      cfg_sync  <= cfg_meta;
    end
  end

  // Spike filter: a low must persist before it counts, both edges
  logic [3:0] filt_cnt;
  logic       line_low;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      filt_cnt <= 4'h0;
      line_low <= 1'b0;
    end else if (line_sync == ~line_low) begin
      filt_cnt <= 4'h0;
    end else if (filt_cnt == 4'(SPIKE_CYC - 1)) begin
      filt_cnt <= 4'h0;
      line_low <= ~line_low;
    end else begin
      filt_cnt <= filt_cnt + 4'h1;
    end
  end

  // Control registers
  logic             exp_en;
  logic             bidir_reset_enable;
  logic             init_done;
  logic [3:0]       status;
  brc_state_t       state;
  brc_state_t       next_state;
  brc_cause_t       cause;
  logic             bidir_active;
  logic             hw_short;

  // Reset entry request, hardware reset taking priority
  logic hw_req;
  logic any_req;
  assign hw_req  = line_low && osc_running;
  assign any_req = hw_req || sw_reset_req || wdt_reset_req;

  // Next state of the reset sequencer
  always_comb begin
    next_state = state;
    case (state)
      BRC_IDLE: begin
        if (any_req) begin
          next_state = BRC_SEQ;
        end
      end
      BRC_SEQ: begin
        if (seq.done) begin
          next_state = line_low ? BRC_WAIT_HIGH : BRC_END;
        end else if (cause == BRC_CAUSE_HW && !bidir_active && !line_low) begin
          // Short reset without bidir ends as soon as the line is back
          next_state = BRC_END;
        end
      end
      BRC_WAIT_HIGH: begin
        if (!line_low) begin
          next_state = BRC_END;
        end
      end
      BRC_END: begin
        next_state = BRC_IDLE;
      end
      default: begin
        next_state = BRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= BRC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Timer start on sequence entry
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      seq.start <= 1'b0;
    end else begin
      seq.start <= (state == BRC_IDLE) && any_req;
    end
  end

  // Capture cause and bidir mode at entry; bidir holds through the sequence
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cause        <= BRC_CAUSE_HW;
      bidir_active <= 1'b0;
      hw_short     <= 1'b0;
    end else if (state == BRC_IDLE && any_req) begin
      cause        <= hw_req ? BRC_CAUSE_HW : (sw_reset_req ? BRC_CAUSE_SW : BRC_CAUSE_WDT);
      bidir_active <= bidir_reset_enable;
      hw_short     <= 1'b0;
    end else if (state == BRC_SEQ && next_state == BRC_END && !seq.done) begin
      hw_short     <= 1'b1;
    end
  end

  // Drive the pin low for the whole internal sequence in bidir mode
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      external_reset_line_oe <= 1'b0;
    end else begin
      // A reset just entering takes its mode from the enable bit itself
      external_reset_line_oe <= (next_state == BRC_SEQ) && (state == BRC_IDLE ?
                                bidir_reset_enable : bidir_active);
    end
  end

  // Open drain: the pin only ever sinks
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      external_reset_line_out <= 1'b0;
    end else begin
      external_reset_line_out <= 1'b0;
    end
  end

  // Internal reset output
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      core_reset <= 1'b1;
    end else begin
      core_reset <= (next_state != BRC_IDLE);
    end
  end

  // Configuration capture at the end of a pin or bidirectional reset, access pin low
  logic take_cfg;
  assign take_cfg = (state == BRC_END) && !acc_sync
                    && (cause == BRC_CAUSE_HW || bidir_active);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      config_latched  <= RST_CONFIG_LATCH;
      bootstrap_start <= 1'b0;
    end else if (take_cfg) begin
      config_latched  <= cfg_sync;
      bootstrap_start <= ~cfg_sync[BIT_BOOT_SEL];
    end
  end

  // Register decode
  logic wr_cfg;
  logic wr_stat;
  always_comb begin
    wr_cfg  = 1'b0;
    wr_stat = 1'b0;
    if (reg_wr && reg_addr == OFS_SYS_CONFIG) begin
      wr_cfg = 1'b1;
    end else if (reg_wr && reg_addr == OFS_RESET_STATUS) begin
      wr_stat = 1'b1;
    end
  end

  // System configuration: init-time bits lock at end of init, clear on reset
  always_ff @(posedge clock) begin
    if (sys_rst || core_reset) begin
      exp_en             <= RST_SYS_CONFIG[BIT_EXP_EN];
      bidir_reset_enable <= RST_SYS_CONFIG[BIT_BIDIR];
      init_done          <= 1'b0;
    end else begin
      if (wr_cfg && !init_done) begin
        exp_en             <= reg_wdata[BIT_EXP_EN];
        bidir_reset_enable <= reg_wdata[BIT_BIDIR];
      end
      if (end_of_init_instruction) begin
        init_done <= 1'b1;
      end
    end
  end

  // Reset source flags; a new event wins over a write-one clear
  logic [3:0] set_flags;
  always_comb begin
    set_flags = 4'h0;
    if (state == BRC_END) begin
      if (bidir_active) begin
        set_flags[BIT_HW_LONG] = 1'b1;
      end else if (cause == BRC_CAUSE_HW) begin
        set_flags[BIT_HW_SHORT] = hw_short;
        set_flags[BIT_HW_LONG]  = ~hw_short;
      end else if (cause == BRC_CAUSE_SW) begin
        set_flags[BIT_SW] = 1'b1;
      end else begin
        set_flags[BIT_WDT] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status <= RST_RESET_STATUS[3:0];
    end else begin
      status <= (status & ~(wr_stat ? reg_wdata[3:0] : 4'h0)) | set_flags;
    end
  end

  // Expansion resources: nothing decoded and no pins claimed while disabled
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ext_ram_enable  <= 1'b0;
      bus_ctrl_enable <= 1'b0;
      serial_enable   <= 1'b0;
    end else begin
      ext_ram_enable  <= exp_en && !core_reset;
      bus_ctrl_enable <= exp_en && !core_reset;
      serial_enable   <= exp_en && !core_reset;
    end
  end

  // Read data, valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == OFS_SYS_CONFIG) begin
        reg_rdata <= 16'h0000;
        reg_rdata[BIT_EXP_EN]   <= exp_en;
        reg_rdata[BIT_BIDIR]    <= bidir_reset_enable;
        reg_rdata[BIT_INITDONE] <= init_done;
      end else if (reg_addr == OFS_RESET_STATUS) begin
        reg_rdata <= {12'h000, status};
      end else if (reg_addr == OFS_CONFIG_LATCH) begin
        reg_rdata <= config_latched;
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

//--- verif/brc_supervisor.sv
// Open-drain reset supervisor model for the reset pin
`timescale 1ns/1ns
`default_nettype none
module brc_supervisor (
  // Clock
  input  wire logic        clock,
  // Command from the bench
  input  wire logic        fire,
  input  wire logic [15:0] hold_cyc,
  // Open-drain sink, high pulls the pin low
  output logic             pull
);
  logic [15:0] left = 16'h0000;

  // Counts the low time; 1 ms is scaled down to keep the run short
  always_ff @(posedge clock) begin
    if (fire) begin
      left <= hold_cyc;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
    end
  end

  // Only ever sinks, so it never fights the device drive
  assign pull = (left != 16'h0000);
endmodule
`default_nettype wire

//--- verif/brc_reset_ctrl_assertions.sv
// Port checker for the reset controller
`timescale 1ns/1ns
`default_nettype none
module brc_reset_ctrl_assertions
  import brc_pkg::*;
#(
  parameter int unsigned SEQ_CYCLES = SEQ_CYC
) (
  // Clock and reset
  input wire logic              clock,
  input wire logic              sys_rst,
  // Register read
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Reset pin and oscillator
  input wire logic              external_reset_line_in,
  input wire logic              external_reset_line_out,
  input wire logic              external_reset_line_oe,
  input wire logic              osc_running,
  // Outputs
  input wire logic              core_reset,
  input wire logic [15:0]       config_latched,
  input wire logic              bootstrap_start,
  input wire logic              ext_ram_enable,
  input wire logic              bus_ctrl_enable,
  input wire logic              serial_enable
);
  logic [15:0] oe_cnt;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Length of each pin drive, judged when it ends
  always_ff @(posedge clock) begin
    if (sys_rst || !external_reset_line_oe) begin
      oe_cnt <= 16'h0000;
    end else begin
      oe_cnt <= oe_cnt + 16'h0001;
    end
  end

  chk_hw_entry: assert property ((!external_reset_line_in && osc_running)[*8] |-> core_reset)
    else $error("low pin did not reset");
  chk_oe_in_reset: assert property (external_reset_line_oe |-> core_reset)
    else $error("pin driven outside reset");
  chk_out_zero: assert property (external_reset_line_out == 1'b0)
    else $error("pin driven high");
  chk_seq_length: assert property ($fell(external_reset_line_oe) |->
    (oe_cnt >= SEQ_CYCLES) && (oe_cnt <= SEQ_CYCLES + 3))
    else $error("pin drive length wrong");
  chk_release_high: assert property ($fell(core_reset) |-> $past(external_reset_line_in, 2))
    else $error("release with pin low");
  chk_boot_inverse: assert property ($changed(config_latched) |->
    bootstrap_start == !config_latched[BIT_BOOT_SEL])
    else $error("boot start wrong");
  chk_enables_agree: assert property (ext_ram_enable == bus_ctrl_enable
    && bus_ctrl_enable == serial_enable)
    else $error("expansion enables differ");
  chk_enables_off: assert property (core_reset ##1 core_reset |->
    !(ext_ram_enable | bus_ctrl_enable | serial_enable))
    else $error("expansion on in reset");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside slot");

  // Main scenarios
  cover property ($rose(external_reset_line_oe));
  cover property ($fell(core_reset));
  cover property ($rose(bootstrap_start));
endmodule

bind brc_reset_ctrl brc_reset_ctrl_assertions #(.SEQ_CYCLES(SEQ_CYCLES)) chk_i (
  .clock, .sys_rst, .reg_rd, .reg_rdata, .external_reset_line_in,
  .external_reset_line_out, .external_reset_line_oe, .osc_running, .core_reset,
  .config_latched, .bootstrap_start, .ext_ram_enable, .bus_ctrl_enable, .serial_enable);
`default_nettype wire

//--- verif/bidirectional_reset_control_test.sv
// Self-checking bench for the reset controller
`timescale 1ns/1ns
`default_nettype none
module bidirectional_reset_control_test
  import brc_pkg::*;
;
  logic        clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, acc_pin = 1'b0;
  logic        osc = 1'b1, sw = 1'b0, wdt = 1'b0, eoi = 1'b0, fire = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, cfg = 16'h0000, hold = 16'h0000, rdata, latched;
  logic        oe, out, core_reset, boot, ram_en, bus_en, ser_en, pull, line;
  logic [15:0] st_exp [4] = '{16'h0004, 16'h0008, 16'h0002, 16'h0001};
  // Pin holds stay above 100 ns plus two clocks; short ends before the sequence
  logic [15:0] hw_len [4] = '{16'h0000, 16'h0000, 16'h0020, 16'h0060};
  int          bad_count = 0, num_checks = 0, len, oen;
  localparam int SEQ_SIM = 64;

  // Open-drain pin with pull-up
  assign line = !(oe | pull);
  initial forever #2 clock = ~clock;

  brc_reset_ctrl #(.SEQ_CYCLES(SEQ_SIM)) uut (.clock(clock), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .external_reset_line_in(line), .external_reset_line_out(out),
    .external_reset_line_oe(oe), .external_access_pin(acc_pin), .config_port(cfg),
    .osc_running(osc), .sw_reset_req(sw), .wdt_reset_req(wdt),
    .end_of_init_instruction(eoi), .core_reset(core_reset), .config_latched(latched),
    .bootstrap_start(boot), .ext_ram_enable(ram_en), .bus_ctrl_enable(bus_en),
    .serial_enable(ser_en));
  brc_supervisor sup (.clock(clock), .fire(fire), .hold_cyc(hold), .pull(pull));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (bad_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  // One reset request, then a fixed window counting reset and pin drive
  task automatic run(input logic s, input logic w, input logic [15:0] h,
                     input logic [15:0] c, output int n, output int d);
    n = 0;
    d = 0;
    @(posedge clock);
    sw <= s;
    wdt <= w;
    fire <= (h != 16'h0000);
    hold <= h;
    cfg <= c;
    @(posedge clock);
    sw <= 1'b0;
    wdt <= 1'b0;
    fire <= 1'b0;
    repeat (200) begin
      @(posedge clock);
      n += core_reset;
      d += oe;
    end
    if (core_reset !== 1'b0) begin
      bad_count++;
      summarize();
    end
  endtask

  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    run(1'b0, 1'b0, 16'h0000, 16'h0000, len, oen);
    rd(OFS_SYS_CONFIG, RST_SYS_CONFIG);
    rd(OFS_RESET_STATUS, RST_RESET_STATUS);
    rd(OFS_CONFIG_LATCH, RST_CONFIG_LATCH);
    rd(8'h0C, 16'h0000);
    wr(OFS_SYS_CONFIG, 16'h000C);
    rd(OFS_SYS_CONFIG, 16'h000C);
    chk(16'(ram_en & bus_en & ser_en), 16'h0001);
    // Bidirectional software reset, boot select low
    run(1'b1, 1'b0, 16'h0000, 16'h00EF, len, oen);
    chk(16'(oen >= SEQ_SIM), 16'h0001);
    chk(16'(len > SEQ_SIM), 16'h0001);
    rd(OFS_RESET_STATUS, 16'h0001);
    rd(OFS_SYS_CONFIG, 16'h0000);
    rd(OFS_CONFIG_LATCH, 16'h00EF);
    chk(16'({boot, ram_en}), 16'h0002);
    // Plain mode: software, watchdog, short and long pin resets
    for (int i = 0; i < 4; i++) begin
      wr(OFS_RESET_STATUS, 16'h000F);
      run(i == 0, i == 1, hw_len[i], 16'h0010, len, oen);
      chk(16'(oen), 16'h0000);
      rd(OFS_RESET_STATUS, st_exp[i]);
      rd(OFS_CONFIG_LATCH, (i < 2) ? 16'h00EF : 16'h0010);
    end
    // Short pin reset stretched in bidirectional mode
    wr(OFS_RESET_STATUS, 16'h000F);
    wr(OFS_SYS_CONFIG, 16'h0008);
    run(1'b0, 1'b0, 16'h0020, 16'h0010, len, oen);
    chk(16'(len > SEQ_SIM), 16'h0001);
    chk(16'(oen >= SEQ_SIM), 16'h0001);
    rd(OFS_RESET_STATUS, 16'h0001);
    // Lock after end of initialisation
    wr(OFS_SYS_CONFIG, 16'h0008);
    @(posedge clock);
    eoi <= 1'b1;
    @(posedge clock);
    eoi <= 1'b0;
    wr(OFS_SYS_CONFIG, 16'h0004);
    rd(OFS_SYS_CONFIG, 16'h0108);
    // Access pin high: a pin reset leaves the latch alone, lock cleared
    @(posedge clock);
    acc_pin <= 1'b1;
    run(1'b0, 1'b0, 16'h0020, 16'h00FF, len, oen);
    rd(OFS_CONFIG_LATCH, 16'h0010);
    chk(16'(boot), 16'h0000);
    rd(OFS_SYS_CONFIG, 16'h0000);
    // Pin low with the oscillator stopped is ignored
    @(posedge clock);
    osc <= 1'b0;
    run(1'b0, 1'b0, 16'h0020, 16'h0010, len, oen);
    chk(16'(len), 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
